// file: rtl/sac_clkdiv.sv
// Purpose: Conversion clock enable derived from the base clock.
// Assumes: The base clock is pclk itself.
// Notes: Emits a one-cycle tick per conversion clock period.
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_clkdiv (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic run,
    input wire logic [2:0] sel,
    output logic phi_tick
);
    logic [3:0] cnt_r;
    logic [3:0] div;
    logic [3:0] gap_r;
    logic seen_r;

    function automatic logic [3:0] sac_div(input logic [2:0] s);
        case (s)
            3'b000: sac_div = `SAC_DIV_4;
            3'b001: sac_div = `SAC_DIV_2;
            3'b010: sac_div = `SAC_DIV_1;
            3'b011: sac_div = `SAC_DIV_1;
            3'b100: sac_div = `SAC_DIV_12;
            3'b101: sac_div = `SAC_DIV_6;
            // The code 111 has no defined rate; the slowest safe pick would waste time, so divide-by-3 is kept.
            default: sac_div = `SAC_DIV_3;
        endcase
    endfunction

    assign div = sac_div(sel);
    assign phi_tick = run & ce & (cnt_r >= div - 4'd1);

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            cnt_r <= 4'h0;
        end else if (ce) begin
            if (!run || phi_tick) begin
                cnt_r <= 4'h0;
            end else begin
                cnt_r <= cnt_r + 4'h1;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            gap_r <= 4'h0;
            seen_r <= 1'b0;
        end else if (ce) begin
            gap_r <= (phi_tick || !run) ? 4'h0 : gap_r + 4'h1;
            seen_r <= run & (seen_r | phi_tick);
        end
    end

    AST_DIV_PERIOD: assert property (@(posedge pclk) disable iff (!presetn)
        phi_tick && seen_r && $stable(sel) && $past(run) |-> gap_r + 4'h1 == div)
        else $error("conversion clock period differs from selected divider");
endmodule

// file: rtl/sac_params.svh
// Purpose: Offsets, field positions, reset values and counts of the converter sequencer.
// Assumes: Register indices are word indices; byte address is four times the index.
// Notes: Definitions only.
`ifndef SAC_PARAMS_SVH
`define SAC_PARAMS_SVH
`define SAC_IDX_CTRL2 12'h3d4
`define SAC_IDX_CTRL0 12'h3d6
`define SAC_IDX_CTRL1 12'h3d7
`define SAC_IDX_RES0 12'h3c0
`define SAC_RST_CTRL0 8'h00
`define SAC_RST_CTRL1 8'h00
`define SAC_RST_CTRL2 8'h00
`define SAC_MASK_CTRL0 8'hff
`define SAC_MASK_CTRL1 8'hf7
`define SAC_MASK_CTRL2 8'h16
`define SAC_CH_LSB 0
`define SAC_MD_LSB 3
`define SAC_TRG_BIT 5
`define SAC_GO_BIT 6
`define SAC_CONV_CLK_SEL_0_BIT 7
`define SAC_SCAN_LSB 0
`define SAC_SWP1_BIT 2
`define SAC_CONV_CLK_SEL_1_BIT 4
`define SAC_PWR_BIT 5
`define SAC_EXT_LSB 6
`define SAC_GRP_LSB 1
`define SAC_CONV_CLK_SEL_2_BIT 4
`define SAC_DIV_4 4'd4
`define SAC_DIV_2 4'd2
`define SAC_DIV_1 4'd1
`define SAC_DIV_12 4'd12
`define SAC_DIV_6 4'd6
`define SAC_DIV_3 4'd3
`define SAC_CONV_CYC 6'd43
`define SAC_SAR_START 6'd33
`define SAC_SAR_MSB 10'h200
`endif

// file: rtl/sac_pkg.sv
// Purpose: Types shared by the converter sequencer files.
// Assumes: Nothing beyond the params header.
// Notes: Encodings follow the mode field.
package sac_pkg;
    typedef enum logic [1:0] {
        SAC_MD_ONESHOT = 2'b00,
        SAC_MD_REPEAT = 2'b01,
        SAC_MD_SWEEP = 2'b10,
        SAC_MD_RSWEEP = 2'b11
    } sac_mode_t;
    typedef enum logic [2:0] {
        SAC_ST_IDLE = 3'b000,
        SAC_ST_WAIT = 3'b001,
        SAC_ST_CONV = 3'b010,
        SAC_ST_STORE = 3'b011,
        SAC_ST_DONE = 3'b100
    } sac_state_t;
endpackage

// file: rtl/sac_top.sv
// Purpose: APB-reached sequencer of a 10-bit successive-approximation converter.
// Assumes: Comparator and external trigger pin are synchronous to pclk.
// Notes: Results of input i land in result register i; an extended input lands in register 1 for ext code 10, else in register 0.
//
// Design decision made here: the APB interface to the registers.
`timescale 1ns/1ps
`include "sac_params.svh"
module sac_top (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic ce,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [15:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic external_start_pin,
    input wire logic ana_cmp,
    output logic ana_power,
    output logic ana_sample,
    output logic [9:0] ana_trial,
    output logic [1:0] ana_group,
    output logic [2:0] ana_chan,
    output logic [1:0] ana_ext,
    output logic conv_done_irq
);
    ////////////////////////////////////////////////////////////////////////////
    logic [7:0] ctrl0_r;
    logic [7:0] ctrl1_r;
    logic [7:0] ctrl2_r;
    logic [9:0] res_r [8];
    logic [31:0] prdata_r;
    logic [3:0] hit;
    logic wr_acc;
    logic phi_tick;
    logic pwr_ready_r;
    logic trig_prev_r;
    logic trig_fall;
    logic go;
    logic trigger_source_sel;
    logic pwr_on;
    logic [2:0] last_idx;
    logic [2:0] first_idx;
    sac_pkg::sac_mode_t mode;
    sac_pkg::sac_state_t state_r;
    sac_pkg::sac_state_t state_nxt;
    logic load;
    logic step;
    logic [5:0] cnt_r;
    logic [9:0] sar_r;
    logic [9:0] mask_r;
    logic [2:0] idx_r;
    logic [1:0] ext_r;
    logic irq_r;

    // Codes: 1..3 control registers, 8..15 result registers, 0 unmapped.
    function automatic logic [3:0] sac_decode(input logic [15:0] a);
        sac_decode = 4'h0;
        if (a[15:14] == 2'b00 && a[1:0] == 2'b00) begin
            if (a[13:2] == `SAC_IDX_CTRL0) begin
                sac_decode = 4'h1;
            end else if (a[13:2] == `SAC_IDX_CTRL1) begin
                sac_decode = 4'h2;
            end else if (a[13:2] == `SAC_IDX_CTRL2) begin
                sac_decode = 4'h3;
            end else if (a[13:5] == `SAC_IDX_RES0 >> 3) begin
                sac_decode = {1'b1, a[4:2]};
            end
        end
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    assign hit = sac_decode(paddr);
    assign wr_acc = ce & psel & penable & pwrite;
    assign pready = 1'b1;
    assign pslverr = psel & penable & (hit == 4'h0);
    assign prdata = prdata_r;

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl0_r <= `SAC_RST_CTRL0;
        end else if (ce) begin
            if (wr_acc && hit == 4'h1) begin
                ctrl0_r <= pwdata[7:0] & `SAC_MASK_CTRL0;
            end else if (state_r == sac_pkg::SAC_ST_DONE) begin
                ctrl0_r[`SAC_GO_BIT] <= 1'b0;
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ctrl1_r <= `SAC_RST_CTRL1;
            ctrl2_r <= `SAC_RST_CTRL2;
        end else if (ce && wr_acc) begin
            if (hit == 4'h2) begin
                ctrl1_r <= pwdata[7:0] & `SAC_MASK_CTRL1;
            end
            if (hit == 4'h3) begin
                ctrl2_r <= pwdata[7:0] & `SAC_MASK_CTRL2;
            end
        end
    end

    // Read data is captured in the setup cycle so that it comes from a flip-flop.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata_r <= 32'h0000_0000;
        end else if (ce && psel && !penable) begin
            case (hit)
                4'h1: prdata_r <= {24'h00_0000, ctrl0_r};
                4'h2: prdata_r <= {24'h00_0000, ctrl1_r};
                4'h3: prdata_r <= {24'h00_0000, ctrl2_r};
                4'h8, 4'h9, 4'ha, 4'hb, 4'hc, 4'hd, 4'he, 4'hf: prdata_r <= {22'h00_0000, res_r[hit[2:0]]};
                default: prdata_r <= 32'h0000_0000;
            endcase
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    assign go = ctrl0_r[`SAC_GO_BIT];
    assign trigger_source_sel = ctrl0_r[`SAC_TRG_BIT];
    assign pwr_on = ctrl1_r[`SAC_PWR_BIT];
    assign mode = sac_pkg::sac_mode_t'(ctrl0_r[`SAC_MD_LSB +: 2]);
    assign last_idx = {ctrl1_r[`SAC_SCAN_LSB +: 2], 1'b1};
    assign ana_power = pwr_on;
    assign ana_group = ctrl2_r[`SAC_GRP_LSB +: 2];
    assign ana_chan = idx_r;
    assign ana_ext = ext_r;
    assign ana_trial = sar_r;
    assign ana_sample = (state_r == sac_pkg::SAC_ST_CONV) && (cnt_r < `SAC_SAR_START);
    assign conv_done_irq = irq_r;
    assign trig_fall = trig_prev_r & ~external_start_pin & go & trigger_source_sel;

    always_comb begin
        if (mode[1]) begin
            first_idx = 3'h0;
        end else if (ctrl1_r[`SAC_EXT_LSB +: 2] != 2'b00) begin
            first_idx = {2'b00, ctrl1_r[`SAC_EXT_LSB +: 2] == 2'b10};
        end else begin
            first_idx = ctrl0_r[`SAC_CH_LSB +: 3];
        end
    end

    sac_clkdiv u_div (
        .pclk(pclk),
        .presetn(presetn),
        .ce(ce),
        .run(pwr_on),
        .sel({ctrl2_r[`SAC_CONV_CLK_SEL_2_BIT], ctrl1_r[`SAC_CONV_CLK_SEL_1_BIT], ctrl0_r[`SAC_CONV_CLK_SEL_0_BIT]}),
        .phi_tick(phi_tick)
    );

    // One conversion clock must pass after power-up before a start is honoured.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            pwr_ready_r <= 1'b0;
            trig_prev_r <= 1'b1;
        end else if (ce) begin
            pwr_ready_r <= pwr_on & (pwr_ready_r | phi_tick);
            trig_prev_r <= external_start_pin;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    always_comb begin
        state_nxt = state_r;
        load = 1'b0;
        step = 1'b0;
        if (!go || !pwr_on) begin
            state_nxt = sac_pkg::SAC_ST_IDLE;
        end else if (trigger_source_sel && trig_fall && state_r != sac_pkg::SAC_ST_IDLE && state_r != sac_pkg::SAC_ST_DONE) begin
            state_nxt = sac_pkg::SAC_ST_CONV;
            load = 1'b1;
        end else begin
            case (state_r)
                sac_pkg::SAC_ST_IDLE: begin
                    if (pwr_ready_r && trigger_source_sel) begin
                        state_nxt = sac_pkg::SAC_ST_WAIT;
                    end else if (pwr_ready_r) begin
                        state_nxt = sac_pkg::SAC_ST_CONV;
                        load = 1'b1;
                    end
                end
                sac_pkg::SAC_ST_WAIT: begin
                    state_nxt = trigger_source_sel ? sac_pkg::SAC_ST_WAIT : sac_pkg::SAC_ST_IDLE;
                end
                sac_pkg::SAC_ST_CONV: begin
                    if (phi_tick && cnt_r == `SAC_CONV_CYC - 6'd1) begin
                        state_nxt = sac_pkg::SAC_ST_STORE;
                    end
                end
                sac_pkg::SAC_ST_STORE: begin
                    case (mode)
                        sac_pkg::SAC_MD_ONESHOT: state_nxt = sac_pkg::SAC_ST_DONE;
                        sac_pkg::SAC_MD_REPEAT: begin
                            state_nxt = sac_pkg::SAC_ST_CONV;
                            load = 1'b1;
                        end
                        sac_pkg::SAC_MD_SWEEP: begin
                            if (idx_r == last_idx) begin
                                state_nxt = sac_pkg::SAC_ST_DONE;
                            end else begin
                                state_nxt = sac_pkg::SAC_ST_CONV;
                                step = 1'b1;
                            end
                        end
                        default: begin
                            state_nxt = sac_pkg::SAC_ST_CONV;
                            load = (idx_r == last_idx);
                            step = (idx_r != last_idx);
                        end
                    endcase
                end
                sac_pkg::SAC_ST_DONE: state_nxt = sac_pkg::SAC_ST_IDLE;
                default: state_nxt = sac_pkg::SAC_ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state_r <= sac_pkg::SAC_ST_IDLE;
            cnt_r <= 6'd0;
            irq_r <= 1'b0;
        end else if (ce) begin
            state_r <= state_nxt;
            irq_r <= (state_r == sac_pkg::SAC_ST_DONE);
            if (load || step || state_nxt != sac_pkg::SAC_ST_CONV) begin
                cnt_r <= 6'd0;
            end else if (phi_tick) begin
                cnt_r <= cnt_r + 6'd1;
            end
        end
    end

    // The trial word holds the decided bits plus the bit under test.
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            sar_r <= 10'h000;
            mask_r <= 10'h000;
        end else if (ce) begin
            if (load) begin
                sar_r <= 10'h000;
                mask_r <= 10'h000;
            end else if (state_r == sac_pkg::SAC_ST_CONV && phi_tick) begin
                if (cnt_r == `SAC_SAR_START - 6'd1) begin
                    sar_r <= `SAC_SAR_MSB;
                    mask_r <= `SAC_SAR_MSB;
                end else if (cnt_r >= `SAC_SAR_START) begin
                    sar_r <= (ana_cmp ? sar_r : (sar_r & ~mask_r)) | (mask_r >> 1);
                    mask_r <= mask_r >> 1;
                end
            end
        end
    end

    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            idx_r <= 3'h0;
            ext_r <= 2'b00;
        end else if (ce) begin
            if (load) begin
                idx_r <= first_idx;
                ext_r <= mode[1] ? 2'b00 : ctrl1_r[`SAC_EXT_LSB +: 2];
            end else if (step) begin
                idx_r <= idx_r + 3'h1;
            end
        end
    end

    generate
        for (genvar i = 0; i < 8; i++) begin : g_res
            always_ff @(posedge pclk or negedge presetn) begin
                if (!presetn) begin
                    res_r[i] <= 10'h000;
                end else if (ce && state_r == sac_pkg::SAC_ST_STORE && idx_r == 3'(i)) begin
                    res_r[i] <= sar_r;
                end
            end
        end
    endgenerate

    ////////////////////////////////////////////////////////////////////////////
    default clocking cb @(posedge pclk); endclocking
    default disable iff (!presetn);

    AST_SW_START: assert property (ce && state_r == sac_pkg::SAC_ST_IDLE && go && !trigger_source_sel && pwr_on && pwr_ready_r
        |=> state_r == sac_pkg::SAC_ST_CONV && cnt_r == 6'd0)
        else $error("software start did not begin a conversion");
    AST_TRIG_START: assert property (ce && state_r == sac_pkg::SAC_ST_WAIT && trig_fall && pwr_on
        |=> state_r == sac_pkg::SAC_ST_CONV && cnt_r == 6'd0)
        else $error("trigger edge did not start a conversion");
    AST_ONESHOT_END: assert property (ce && state_r == sac_pkg::SAC_ST_STORE && go && pwr_on && !trig_fall
        && mode == sac_pkg::SAC_MD_ONESHOT |=> state_r == sac_pkg::SAC_ST_DONE ##1 !go || !ce)
        else $error("one-shot did not clear the go flag");
    AST_ABORT: assert property (ce && wr_acc && hit == 4'h1 && !pwdata[`SAC_GO_BIT] ##1 ce
        |=> state_r == sac_pkg::SAC_ST_IDLE)
        else $error("go flag cleared but conversion kept running");
    AST_IRQ_SRC: assert property ($rose(irq_r) |-> $past(state_r) == sac_pkg::SAC_ST_DONE
        && $past(mode) != sac_pkg::SAC_MD_REPEAT)
        else $error("interrupt raised without a completion");
    AST_CONV_LEN: assert property (ce && state_r == sac_pkg::SAC_ST_CONV ##1 state_r == sac_pkg::SAC_ST_STORE
        |-> $past(cnt_r) == `SAC_CONV_CYC - 6'd1)
        else $error("conversion ended before its full cycle count");
    AST_NEXT_CNT: assert property (ce && state_r == sac_pkg::SAC_ST_STORE ##1 state_r == sac_pkg::SAC_ST_CONV
        |-> cnt_r == 6'd0)
        else $error("next conversion began with a stale cycle count");
    AST_SAR_MSB: assert property (ce && state_r == sac_pkg::SAC_ST_CONV && phi_tick && !load
        && cnt_r == `SAC_SAR_START - 6'd1 |=> mask_r == `SAC_SAR_MSB)
        else $error("approximation did not start at the top bit");
    AST_RESULT: assert property (ce && state_r == sac_pkg::SAC_ST_STORE |=> res_r[$past(idx_r)] == $past(sar_r))
        else $error("result not written to register of its input");
    AST_STANDBY: assert property (ce && !pwr_on |=> state_r == sac_pkg::SAC_ST_IDLE && !pwr_ready_r)
        else $error("converter active while in standby");
    AST_RSV_READ: assert property (psel && penable && hit == 4'h3 |-> prdata[0] == 1'b0)
        else $error("unimplemented bit reads nonzero");
    AST_SWEEP_END: assert property (ce && state_r == sac_pkg::SAC_ST_STORE && go && pwr_on && !trig_fall
        && mode == sac_pkg::SAC_MD_SWEEP && idx_r == last_idx |=> state_r == sac_pkg::SAC_ST_DONE)
        else $error("single sweep did not finish at last input");

    COV_ONESHOT: cover property (state_r == sac_pkg::SAC_ST_DONE && mode == sac_pkg::SAC_MD_ONESHOT);
    COV_SWEEP8: cover property (state_r == sac_pkg::SAC_ST_STORE && mode == sac_pkg::SAC_MD_RSWEEP && idx_r == 3'h7);
    COV_RETRIG: cover property (state_r == sac_pkg::SAC_ST_CONV && trig_fall && ce);
endmodule

// file: test/sac_ana_model.sv
// Purpose: Comparator and input multiplexer seen from the sequencer.
// Assumes: Each input holds a level derived from the bench's base level.
// Notes: An unpowered comparator toggles, so a start that slips past standby shows up as a wrong result.
`timescale 1ns/1ps
module sac_ana_model (
    input wire logic pclk,
    input wire logic ana_power,
    input wire logic [9:0] ana_trial,
    input wire logic [1:0] ana_group,
    input wire logic [2:0] ana_chan,
    input wire logic [1:0] ana_ext,
    input wire logic [9:0] base,
    output logic ana_cmp
);
    logic junk_r = 1'b0;
    logic [9:0] lvl;
    always_ff @(posedge pclk) begin
        junk_r <= ~junk_r;
    end
    assign lvl = (ana_ext != 2'b00) ? (base ^ {ana_ext, 8'h5a}) : (base ^ {2'b00, ana_group, ana_chan, 3'h0});
    assign ana_cmp = ana_power ? (lvl >= ana_trial) : junk_r;
endmodule

// file: test/tb.sv
// Purpose: Self-checking bench of the converter sequencer.
// Assumes: The comparator model stands in for the analog side.
// Notes: Random values come from a 16-bit shift register seeded at 50.
`timescale 1ns/1ps
`include "sac_params.svh"
`define CHK(nm, e, g) begin checks_done++; if ((g) !== (e)) begin errors++; \
    $display("wrong value %s exp %0h got %0h", nm, e, g); end end
module tb;
    localparam logic [15:0] a0 = {2'b00, `SAC_IDX_CTRL0, 2'b00};
    localparam logic [15:0] a1 = {2'b00, `SAC_IDX_CTRL1, 2'b00};
    localparam logic [15:0] a2 = {2'b00, `SAC_IDX_CTRL2, 2'b00};
    logic pclk, presetn, ce, psel, penable, pwrite, external_start_pin, ana_cmp, er;
    logic pready, pslverr, ana_power, ana_sample, conv_done_irq;
    logic [15:0] paddr, r;
    logic [31:0] pwdata, prdata, q;
    logic [9:0] ana_trial, ana_level;
    logic [1:0] ana_group, ana_ext, g, e;
    logic [2:0] ana_chan, c, ix;
    logic [15:0] lf = 16'h0032;
    logic [9:0] expr [8];
    logic [15:0] ra [3] = '{a0, a1, a2};
    logic [7:0] mk [3] = '{8'hff, 8'hf7, 8'h16};
    logic [1:0] gtab [3] = '{2'b00, 2'b10, 2'b11};
    int dtab [8] = '{4, 2, 1, 1, 12, 6, 3, 3};
    int irq_cnt = 0;
    int errors = 0;
    int checks_done = 0;
    int k, dv;
    ////////////////////////////////////////
    sac_top sac_top_i (.pclk(pclk), .presetn(presetn), .ce(ce), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .external_start_pin(external_start_pin), .ana_cmp(ana_cmp),
        .ana_power(ana_power), .ana_sample(ana_sample), .ana_trial(ana_trial), .ana_group(ana_group),
        .ana_chan(ana_chan), .ana_ext(ana_ext), .conv_done_irq(conv_done_irq));
    sac_ana_model sac_ana_model_i (.pclk(pclk), .ana_power(ana_power), .ana_trial(ana_trial),
        .ana_group(ana_group), .ana_chan(ana_chan), .ana_ext(ana_ext), .base(ana_level), .ana_cmp(ana_cmp));
    initial begin
        pclk = 1'b0;
        forever #12.5 pclk = ~pclk;
    end
    // Counted mid-cycle so the pulse is settled when it is seen.
    always @(negedge pclk) begin
        if (conv_done_irq === 1'b1) irq_cnt++;
    end
    ////////////////////////////////////////
    function [15:0] rnd();
        lf = {lf[14:0], lf[15] ^ lf[13] ^ lf[12] ^ lf[10]};
        return lf;
    endfunction
    function automatic [9:0] lv(input [1:0] gg, input [2:0] cc, input [1:0] ee);
        return (ee != 2'b00) ? (ana_level ^ {ee, 8'h5a}) : (ana_level ^ {2'b00, gg, cc, 3'h0});
    endfunction
    task bus(input [15:0] a, input w, input [7:0] d);
        @(posedge pclk);
        psel <= 1'b1;
        penable <= 1'b0;
        paddr <= a;
        pwrite <= w;
        pwdata <= {24'h0, d};
        @(posedge pclk);
        penable <= 1'b1;
        do @(posedge pclk); while (pready !== 1'b1);
        q = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask
    task cfg(input [2:0] ck, input [1:0] gg, input [1:0] sc, input [1:0] ee);
        bus(a2, 1'b1, {3'h0, ck[2], 1'b0, gg, 1'b0});
        bus(a1, 1'b1, {ee, 1'b1, ck[1], 2'b00, sc});
        repeat (30) @(posedge pclk);
        dv = dtab[ck];
    endtask
    task wt(input int mx);
        int n;
        n = irq_cnt;
        k = 0;
        while (irq_cnt == n && k < mx) begin
            @(posedge pclk);
            k++;
        end
    endtask
    task cr(input [2:0] i);
        bus({2'b00, `SAC_IDX_RES0 + 12'(i), 2'b00}, 1'b0, 8'h00);
        `CHK("result", {22'h0, expr[i]}, q)
    endtask
    task results;
        $display("checks %0d errors %0d", checks_done, errors);
        if (errors == 0 && checks_done > 0)
            $display("[ PASS ]");
        else
            $display("[ FAIL ]");
        $finish;
    endtask
    ////////////////////////////////////////
    initial begin
        {psel, penable, pwrite, paddr, pwdata} = '0;
        presetn = 1'b0;
        ce = 1'b1;
        external_start_pin = 1'b1;
        ana_level = 10'h000;
        foreach (expr[i]) expr[i] = 10'h000;
        repeat (16) @(posedge pclk);
        presetn <= 1'b1;
        for (int i = 0; i < 3; i++) begin
            bus(ra[i], 1'b0, 8'h00);
            `CHK("reset", 32'h0, q)
        end
        bus(a0, 1'b1, 8'h40);
        wt(100);
        `CHK("standby", 100, k)
        for (int i = 0; i < 3; i++) bus(ra[i], 1'b1, 8'hff);
        `CHK("power", 1'b1, ana_power)
        for (int i = 0; i < 3; i++) begin
            bus(ra[i], 1'b0, 8'h00);
            `CHK("mask", {24'h0, mk[i]}, q)
        end
        bus(a0, 1'b1, 8'h00);
        bus(16'h0ff0, 1'b0, 8'h00);
        `CHK("slverr", 1'b1, er)
        `CHK("unmapped", 32'h0, q)
        // One-shot over every divider code, then extended input codes 01 and 10.
        for (int i = 0; i < 10; i++) begin
            r = rnd();
            e = (i > 7) ? 2'(i - 7) : 2'b00;
            g = gtab[r[12:11] % 3];
            c = r[15:13];
            ana_level = r[9:0];
            cfg(3'(i), g, 2'b00, e);
            ix = (e != 2'b00) ? 3'(e - 1) : c;
            expr[ix] = lv(g, c, e);
            bus(a0, 1'b1, {1'(i), 1'b1, 1'b0, 2'b00, c});
            wt(44 * dv + 20);
            `CHK("irq", 1'b1, k < 44 * dv + 20)
            `CHK("length", 1'b1, k > 42 * dv)
            bus(a0, 1'b0, 8'h00);
            `CHK("go clear", 1'b0, q[6])
            cr(ix);
        end
        cfg(3'b100, 2'b00, 2'b00, 2'b00);
        ana_level = ~ana_level;
        bus(a0, 1'b1, 8'h43);
        repeat (60) @(posedge pclk);
        `CHK("sampling", 1'b1, ana_sample)
        bus(a0, 1'b1, 8'h03);
        wt(700);
        `CHK("abort irq", 700, k)
        `CHK("sample end", 1'b0, ana_sample)
        cr(3'd3);
        cfg(3'b010, 2'b10, 2'b00, 2'b00);
        bus(a0, 1'b1, 8'h4d);
        wt(150);
        `CHK("repeat irq", 150, k)
        r = rnd();
        ana_level = r[9:0];
        expr[5] = lv(2'b10, 3'd5, 2'b00);
        wt(150);
        `CHK("repeat irq", 150, k)
        cr(3'd5);
        bus(a0, 1'b0, 8'h00);
        `CHK("go held", 1'b1, q[6])
        bus(a0, 1'b1, 8'h0d);
        // Four sweep sets once, then repeat sweep stopped by software.
        for (int s = 0; s < 5; s++) begin
            r = rnd();
            g = gtab[r[12:11] % 3];
            ana_level = r[9:0];
            cfg(3'b010, g, 2'(s), 2'b00);
            for (int j = 0; j < 2 * (s % 4) + 2; j++) expr[j] = lv(g, 3'(j), 2'b00);
            bus(a0, 1'b1, {2'b01, 1'b0, (s < 4) ? 2'b10 : 2'b11, 3'b000});
            wt(420);
            if (s == 4) begin
                `CHK("rsweep irq", 420, k)
                bus(a0, 1'b1, 8'h18);
            end else begin
                `CHK("sweep irq", 1'b1, k < 420)
                bus(a0, 1'b0, 8'h00);
                `CHK("sweep go", 1'b0, q[6])
            end
            for (int j = 0; j < 2 * (s % 4) + 2; j++) cr(3'(j));
        end
        cfg(3'b010, 2'b00, 2'b00, 2'b00);
        expr[2] = lv(2'b00, 3'd2, 2'b00);
        bus(a0, 1'b1, 8'h22);
        external_start_pin <= 1'b0;
        wt(40);
        external_start_pin <= 1'b1;
        `CHK("edge ignored", 40, k)
        bus(a0, 1'b1, 8'h62);
        wt(60);
        `CHK("wait edge", 60, k)
        external_start_pin <= 1'b0;
        wt(80);
        `CHK("edge start", 1'b1, k < 80)
        cr(3'd2);
        external_start_pin <= 1'b1;
        bus(a0, 1'b1, 8'h62);
        repeat (10) @(posedge pclk);
        external_start_pin <= 1'b0;
        repeat (20) @(posedge pclk);
        external_start_pin <= 1'b1;
        @(posedge pclk);
        external_start_pin <= 1'b0;
        wt(80);
        `CHK("retrigger", 1'b1, k > 40)
        cr(3'd2);
        external_start_pin <= 1'b1;
        results;
    end
    initial begin
        repeat (40000) @(posedge pclk);
        errors++;
        results;
    end
endmodule
